// file: shared/efuse_pkg.sv
// Constants, register map and state codes of the fault supervisor.
// Assumes a single 100 MHz clock and comparator flags from the analog side.
package efuse_pkg;

  localparam int CLK_PERIOD_NS = 10;

  function automatic int cycles_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cycles_up

  ////////////////////////////////////////////////////////////////////////////
  // Times in ns and their cycle counts
  localparam int GOOD_ASSERT_DEGLITCH_NS = 1000;
  localparam int GOOD_DEASSERT_DEGLITCH_NS = 1000;
  localparam int GS_FAULT_DELAY_NS = 10000;
  localparam int DISCHARGE_QUALIFY_TIME_NS = 50000;
  localparam int RETRY_DELAY_NS = 1000000;
  localparam int STARTUP_TIMEOUT_NS = 20000000;
  localparam int OVERCURRENT_BLANKING_TIMER_NS = 400000;
  localparam int PGA_CYCLES = cycles_up(GOOD_ASSERT_DEGLITCH_NS);
  localparam int PGD_CYCLES = cycles_up(GOOD_DEASSERT_DEGLITCH_NS);
  localparam int GS_CYCLES = cycles_up(GS_FAULT_DELAY_NS);
  localparam int QOD_CYCLES = cycles_up(DISCHARGE_QUALIFY_TIME_NS);
  localparam int RST_CYCLES = cycles_up(RETRY_DELAY_NS);
  localparam int SU_CYCLES = cycles_up(STARTUP_TIMEOUT_NS);
  localparam int ITIMER_CYCLES = cycles_up(OVERCURRENT_BLANKING_TIMER_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] FAULT_OFFSET = 4'h4;
  localparam logic [3:0] STATE_OFFSET = 4'h8;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Latched fault bit positions
  localparam int NUM_FAULTS = 7;
  localparam int F_OT = 0;
  localparam int F_CB = 1;
  localparam int F_FT = 2;
  localparam int F_SU = 3;
  localparam int F_GS = 4;
  localparam int F_GD = 5;
  localparam int F_PEER = 6;
  localparam int PEER_GUARD = 3;

  typedef enum logic [2:0] {
    S_OFF = 3'h0,
    S_INRUSH = 3'h1,
    S_ON = 3'h3,
    S_COOL = 3'h2,
    S_RETRY = 3'h6,
    S_LATCHED = 3'h7
  } sup_state_t;

endpackage : efuse_pkg

// file: src/delay_timer.sv
// Qualification timer: done after CYCLES edges with run held high.
// Assumes run drops to restart; dropping run clears done at once and the count on the next edge.
`timescale 1ns/10ps
module delay_timer #(
  parameter int CYCLES = 4
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic run_in,
  output logic done_out
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LIMIT = W'(CYCLES);
  logic [W-1:0] count_reg;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      count_reg <= '0;
    else if (!run_in)
      count_reg <= '0;
    else if (count_reg != LIMIT)
      count_reg <= count_reg + 1'b1;
  end

  assign done_out = run_in && (count_reg == LIMIT);
endmodule : delay_timer

// file: src/efuse_fault_supervisor.sv
// Fault supervisor: switch state machine, fault latches, fault line,
// power-good deglitch, output discharge and AXI4-Lite registers.
// Assumes comparator flags are asynchronous levels; AXI is on clk_in.
`timescale 1ns/10ps
module efuse_fault_supervisor #(
  parameter int QOD_CYCLES = efuse_pkg::QOD_CYCLES,
  parameter int RST_CYCLES = efuse_pkg::RST_CYCLES,
  parameter int SU_CYCLES = efuse_pkg::SU_CYCLES,
  parameter int ITIMER_CYCLES = efuse_pkg::ITIMER_CYCLES
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic en_above_sd_in,
  input wire logic en_above_lockout_in,
  input wire logic tj_over_tsd_in,
  input wire logic tj_cooled_in,
  input wire logic oc_over_in,
  input wire logic fast_trip_in,
  input wire logic vin_uvp_in,
  input wire logic vin_ovp_in,
  input wire logic gate_overdrive_in,
  input wire logic gate_near_vin_in,
  input wire logic gs_low_in,
  input wire logic vout_below_fb_in,
  input wire logic mode_open_in,
  input wire logic fault_indicator_line_in,
  output logic fault_indicator_line_out,
  output logic fault_indicator_line_oe_out,
  output logic gate_on_out,
  output logic power_good_output_out,
  output logic discharge_out,
  input wire logic [efuse_pkg::ADDR_W-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [efuse_pkg::ADDR_W-1:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in
);
  localparam int NF = efuse_pkg::NUM_FAULTS;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  logic en_sd_ok_s, en_on_s, tj_over_s, cooled_s, oc_s, ft_s, uvp_s, ovp_s;
  logic overdrive_s, near_vin_s, gs_low_s, below_fb_s, mode_open_s, line_low_s;

  // Line is inverted before sync so the reset value reads as released, not as a peer fault
  sync_bits #(.WIDTH(14)) u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in({en_above_sd_in, en_above_lockout_in, tj_over_tsd_in, tj_cooled_in,
               oc_over_in, fast_trip_in, vin_uvp_in, vin_ovp_in, gate_overdrive_in,
               gate_near_vin_in, gs_low_in, vout_below_fb_in, mode_open_in,
               !fault_indicator_line_in}),
    .sync_out({en_sd_ok_s, en_on_s, tj_over_s, cooled_s, oc_s, ft_s, uvp_s, ovp_s,
               overdrive_s, near_vin_s, gs_low_s, below_fb_s, mode_open_s, line_low_s})
  );

  efuse_pkg::sup_state_t state_reg, state_next;
  logic [NF-1:0] faults_reg, faults_set;
  logic [efuse_pkg::PEER_GUARD-1:0] oe_hist_reg;
  logic inhibit_reg, gate_reg, pg_reg, dis_reg, dis_stop_reg, oe_reg;
  logic clear_all, retry_clear, any_fault, trip_auto, en_sd;
  logic su_done, itimer_done, gs_done, rst_done, qod_done, pga_done, pgd_done;
  logic in_window, drive_line;

  assign en_sd = !en_sd_ok_s;
  assign in_window = en_sd_ok_s && !en_on_s;
  // Grounded mode input selects auto-retry
  assign trip_auto = !mode_open_s;

  ////////////////////////////////////////////////////////////////////////////
  // Timers
  delay_timer #(.CYCLES(SU_CYCLES)) u_su (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .run_in(state_reg == efuse_pkg::S_INRUSH), .done_out(su_done));
  delay_timer #(.CYCLES(ITIMER_CYCLES)) u_itimer (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .run_in(state_reg == efuse_pkg::S_ON && oc_s), .done_out(itimer_done));
  delay_timer #(.CYCLES(efuse_pkg::GS_CYCLES)) u_gs (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .run_in(state_reg == efuse_pkg::S_ON && gs_low_s), .done_out(gs_done));
  // Leaving retry on shutdown-level enable restarts this count
  delay_timer #(.CYCLES(RST_CYCLES)) u_rst (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .run_in(state_reg == efuse_pkg::S_RETRY), .done_out(rst_done));
  delay_timer #(.CYCLES(QOD_CYCLES)) u_qod (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .run_in(in_window), .done_out(qod_done));
  delay_timer #(.CYCLES(efuse_pkg::PGA_CYCLES)) u_pga (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .run_in(state_reg == efuse_pkg::S_ON), .done_out(pga_done));
  delay_timer #(.CYCLES(efuse_pkg::PGD_CYCLES)) u_pgd (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .run_in(state_reg != efuse_pkg::S_ON), .done_out(pgd_done));

  ////////////////////////////////////////////////////////////////////////////
  // Fault latches
  always_comb
  begin
    faults_set = '0;
    faults_set[efuse_pkg::F_OT] = tj_over_s;
    faults_set[efuse_pkg::F_CB] = itimer_done;
    faults_set[efuse_pkg::F_FT] = ft_s && gate_reg;
    faults_set[efuse_pkg::F_SU] = su_done;
    faults_set[efuse_pkg::F_GS] = su_done || gs_done;
    faults_set[efuse_pkg::F_GD] = near_vin_s && !gate_reg;
    // Own release needs a few cycles to show on the line
    faults_set[efuse_pkg::F_PEER] = line_low_s && (oe_hist_reg == '0);
  end

  assign clear_all = en_sd;
  assign retry_clear = state_reg == efuse_pkg::S_RETRY && rst_done && en_on_s;
  assign any_fault = (faults_reg != '0) || (faults_set != '0);

  // Set wins over clear so an event in the clearing cycle is kept
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      faults_reg <= '0;
    else
      faults_reg <= (faults_reg & {NF{!(clear_all || retry_clear)}}) | faults_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch state machine
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      efuse_pkg::S_OFF, efuse_pkg::S_INRUSH, efuse_pkg::S_ON:
      begin
        if (any_fault && !en_sd)
          state_next = trip_auto ? efuse_pkg::S_COOL : efuse_pkg::S_LATCHED;
        else if (!en_on_s || uvp_s || ovp_s || inhibit_reg)
          state_next = efuse_pkg::S_OFF;
        else if (state_reg == efuse_pkg::S_OFF)
          state_next = efuse_pkg::S_INRUSH;
        else if (state_reg == efuse_pkg::S_INRUSH && overdrive_s)
          state_next = efuse_pkg::S_ON;
      end
      efuse_pkg::S_LATCHED:
      begin
        if (en_sd)
          state_next = efuse_pkg::S_OFF;
      end
      efuse_pkg::S_COOL:
      begin
        if (en_sd)
          state_next = efuse_pkg::S_OFF;
        else if (cooled_s && !tj_over_s)
          state_next = efuse_pkg::S_RETRY;
      end
      efuse_pkg::S_RETRY:
      begin
        if (en_sd)
          state_next = efuse_pkg::S_OFF;
        // A fault seen in the retry cycle itself must not let the gate rise
        else if (retry_clear && faults_set == '0 && !inhibit_reg && !uvp_s && !ovp_s)
          state_next = efuse_pkg::S_INRUSH;
      end
      default: state_next = efuse_pkg::S_OFF;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      state_reg <= efuse_pkg::S_OFF;
    else
      state_reg <= state_next;
  end

  // Gate drive follows the next state so a fault pulls it low at once
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      gate_reg <= 1'b0;
    else
      gate_reg <= state_next == efuse_pkg::S_INRUSH || state_next == efuse_pkg::S_ON;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault line: open drain, drives low only
  assign drive_line = (faults_reg != '0) || (faults_set != '0) || in_window || ovp_s
                      || (uvp_s && state_reg != efuse_pkg::S_ON)
                      || (oc_s && state_reg == efuse_pkg::S_INRUSH);

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      oe_reg <= 1'b0;
      oe_hist_reg <= '0;
    end
    else
    begin
      oe_reg <= drive_line;
      oe_hist_reg <= {oe_hist_reg[efuse_pkg::PEER_GUARD-2:0], oe_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-good: low from reset, set and cleared through deglitch timers
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      pg_reg <= 1'b0;
    else if (pga_done)
      pg_reg <= 1'b1;
    else if (pgd_done)
      pg_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output discharge; once stopped it stays off until the window is left
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      dis_stop_reg <= 1'b0;
    else if (!in_window)
      dis_stop_reg <= 1'b0;
    else if (below_fb_s || any_fault || tj_over_s)
      dis_stop_reg <= 1'b1;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      dis_reg <= 1'b0;
    else
      dis_reg <= qod_done && !dis_stop_reg && !below_fb_s && !any_fault && !tj_over_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; ready is a one-cycle registered offer
  logic aw_full_reg, w_full_reg, awready_reg, wready_reg, bvalid_reg;
  logic arready_reg, rvalid_reg;
  logic [efuse_pkg::ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic do_write;

  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end
    else
    begin
      awready_reg <= awvalid_in && !awready_reg && !aw_full_reg && !bvalid_reg;
      wready_reg <= wvalid_in && !wready_reg && !w_full_reg && !bvalid_reg;
      if (awvalid_in && awready_reg)
      begin
        aw_full_reg <= 1'b1;
        waddr_reg <= awaddr_in;
      end
      else if (do_write)
        aw_full_reg <= 1'b0;
      if (wvalid_in && wready_reg)
      begin
        w_full_reg <= 1'b1;
        wdata_reg <= wdata_in;
        wstrb_reg <= wstrb_in;
      end
      else if (do_write)
        w_full_reg <= 1'b0;
    end
  end

  // Software inhibit holds the switch off without clearing faults
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      inhibit_reg <= efuse_pkg::CTRL_RESET;
      bvalid_reg <= 1'b0;
      bresp_reg <= efuse_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= efuse_pkg::RESP_OKAY;
      if (waddr_reg == efuse_pkg::CTRL_OFFSET)
      begin
        if (wstrb_reg[0])
          inhibit_reg <= wdata_reg[0];
      end
      else if (waddr_reg != efuse_pkg::FAULT_OFFSET && waddr_reg != efuse_pkg::STATE_OFFSET)
        bresp_reg <= efuse_pkg::RESP_SLVERR;
    end
    else if (bvalid_reg && bready_in)
      bvalid_reg <= 1'b0;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= efuse_pkg::RESP_OKAY;
    end
    else
    begin
      arready_reg <= arvalid_in && !arready_reg && !rvalid_reg;
      if (arvalid_in && arready_reg)
      begin
        rvalid_reg <= 1'b1;
        rresp_reg <= efuse_pkg::RESP_OKAY;
        unique case (araddr_in)
          efuse_pkg::CTRL_OFFSET: rdata_reg <= {31'h0, inhibit_reg};
          efuse_pkg::FAULT_OFFSET: rdata_reg <= {25'h0, faults_reg};
          efuse_pkg::STATE_OFFSET:
            rdata_reg <= {24'h0, trip_auto, oe_reg, gate_reg, dis_reg, pg_reg, state_reg};
          default:
          begin
            rdata_reg <= '0;
            rresp_reg <= efuse_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (rvalid_reg && rready_in)
        rvalid_reg <= 1'b0;
    end
  end

  assign fault_indicator_line_out = 1'b0;
  assign fault_indicator_line_oe_out = oe_reg;
  assign gate_on_out = gate_reg;
  assign power_good_output_out = pg_reg;
  assign discharge_out = dis_reg;
  assign awready_out = awready_reg;
  assign wready_out = wready_reg;
  assign bvalid_out = bvalid_reg;
  assign bresp_out = bresp_reg;
  assign arready_out = arready_reg;
  assign rvalid_out = rvalid_reg;
  assign rdata_out = rdata_reg;
  assign rresp_out = rresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_latch_holds_off: assert property (
    state_reg == efuse_pkg::S_LATCHED && !en_sd |=> state_reg == efuse_pkg::S_LATCHED
      && !gate_on_out) else $error("latched state left without clear");
  a_cool_before_retry: assert property (
    state_reg == efuse_pkg::S_COOL && !cooled_s |=> state_reg != efuse_pkg::S_RETRY
      && !gate_on_out) else $error("retry began before cooling");
  a_retry_needs_enable: assert property (
    state_reg == efuse_pkg::S_INRUSH && $past(state_reg) == efuse_pkg::S_RETRY
      |-> $past(en_on_s) && $past(rst_done)) else $error("retry without enable");
  a_clear_empties: assert property (
    en_sd && faults_set == '0 |=> faults_reg == '0) else $error("faults not cleared");
  a_clear_stops_retry: assert property (
    en_sd |=> state_reg == efuse_pkg::S_OFF) else $error("clear did not end retry");
  a_lockout_keeps: assert property (
    faults_reg != '0 && !en_sd && !retry_clear |=> faults_reg != '0)
    else $error("fault lost without shutdown");
  a_fault_drives_pin: assert property (
    faults_reg != '0 |=> fault_indicator_line_oe_out) else $error("pin not driven");
  a_gd_gate_low: assert property (
    faults_set[efuse_pkg::F_GD] && !en_sd |=> !gate_on_out ##1 !gate_on_out)
    else $error("gate left on after short");
  a_pg_after_on: assert property (
    $rose(power_good_output_out) |-> $past(state_reg == efuse_pkg::S_ON, 2)
      && $past(state_reg == efuse_pkg::S_ON, 1)) else $error("pg rose early");
  a_pg_inrush_low: assert property (
    state_reg == efuse_pkg::S_INRUSH && $past(pg_reg) == 1'b0 |=> !power_good_output_out)
    else $error("pg high in inrush");
  a_dis_stops: assert property (
    below_fb_s || any_fault |=> !discharge_out) else $error("discharge not stopped");
  a_dis_hot_off: assert property (
    tj_over_s |=> !discharge_out) else $error("discharge while hot");
  a_shutdown_quiet: assert property (
    en_sd |=> !gate_on_out && !discharge_out) else $error("active in shutdown");
endmodule : efuse_fault_supervisor

// file: src/sync_bits.sv
// Two-stage synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; no bus coherence between bits.
`timescale 1ns/10ps
module sync_bits #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : sync_bits

// file: verif/peer_model.sv
// Paralleled peer switch and pull-up on the shared fault line.
// Assumes the supervisor's output enable means it sinks the line.
`timescale 1ns/10ps
module peer_model (
  input wire logic dut_oe_in,
  input wire logic peer_fault_in,
  output logic line_out
);
  // Pull-up reads high unless some party sinks the line
  assign line_out = !(dut_oe_in || peer_fault_in);
endmodule : peer_model

// file: verif/testbench.sv
// Bench for the fault supervisor: comparator levels and AXI4-Lite reads and writes.
// Assumes shortened counts below; peer_model closes the fault line.
`timescale 1ns/10ps
module testbench;
  logic clk_in = 1'h0;
  logic resetn_in = 1'h0;
  logic sd, lo, ot, cl, oc, ft, uv, ov, od, gv, gs, fb, md, pf, line, oe;
  logic gate, pg, dis, awv, wv, br, arv, rr, awr, wr, bv, arr, rv, ta, tw, tb;
  logic [3:0] aw, ar, ws;
  logic [31:0] wd, rd, d;
  logic [1:0] bresp, rresp, r;
  int errors = 0;
  int n_checks = 0;
  always #5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////
  efuse_fault_supervisor #(.QOD_CYCLES(20), .RST_CYCLES(50), .SU_CYCLES(200),
    .ITIMER_CYCLES(30)) u_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .en_above_sd_in(sd),
    .en_above_lockout_in(lo), .tj_over_tsd_in(ot), .tj_cooled_in(cl),
    .oc_over_in(oc), .fast_trip_in(ft), .vin_uvp_in(uv), .vin_ovp_in(ov),
    .gate_overdrive_in(od), .gate_near_vin_in(gv), .gs_low_in(gs),
    .vout_below_fb_in(fb), .mode_open_in(md), .fault_indicator_line_in(line),
    .fault_indicator_line_out(), .fault_indicator_line_oe_out(oe), .gate_on_out(gate),
    .power_good_output_out(pg), .discharge_out(dis), .awaddr_in(aw), .awvalid_in(awv),
    .awready_out(awr), .wdata_in(wd), .wstrb_in(ws), .wvalid_in(wv), .wready_out(wr),
    .bresp_out(bresp), .bvalid_out(bv), .bready_in(br), .araddr_in(ar),
    .arvalid_in(arv), .arready_out(arr), .rdata_out(rd), .rresp_out(rresp),
    .rvalid_out(rv), .rready_in(rr));
  peer_model u_peer (.dut_oe_in(oe), .peer_fault_in(pf), .line_out(line));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // Ready is registered, so the level seen at the falling edge is what the
  // next rising edge samples; this keeps the bench out of edge races
  task automatic wait_ok(input logic t);
    chk("handshake", t, 1'h1);
    if (t !== 1'h1)
      close_out();
    tick(1);
  endtask : wait_ok

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] s);
    int k;
    k = 0;
    aw <= a;
    wd <= v;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    do
    begin
      @(negedge clk_in);
      ta = awr;
      tw = wr;
      tb = bv;
      s = bresp;
      @(posedge clk_in);
      if (ta)
        awv <= 1'h0;
      if (tw)
        wv <= 1'h0;
      k++;
    end while (tb !== 1'h1 && k < 50);
    br <= 1'h0;
    wait_ok(tb);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] s);
    int k;
    k = 0;
    ar <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    do
    begin
      @(negedge clk_in);
      ta = arr;
      tb = rv;
      v = rd;
      s = rresp;
      @(posedge clk_in);
      if (ta)
        arv <= 1'h0;
      k++;
    end while (tb !== 1'h1 && k < 50);
    rr <= 1'h0;
    wait_ok(tb);
  endtask : axi_rd

  task automatic flt(input logic [6:0] e);
    axi_rd(efuse_pkg::FAULT_OFFSET, d, r);
    chk("faults", d[6:0], e);
  endtask : flt

  task automatic up();
    {sd, lo, od} <= 3'h7;
    tick(8);
    chk("gate", gate, 1'h1);
  endtask : up

  task automatic clr(input string nm);
    {sd, lo, ot, cl, oc, ft, od, gv, gs, fb, pf} <= '0;
    tick(8);
    flt(7'h00);
    chk("oe", oe, 1'h0);
    chk("line", line, 1'h1);
    $display("%s test done", nm);
  endtask : clr
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {sd, lo, ot, cl, oc, ft, uv, ov, od, gv, gs, fb, pf, awv, wv, br, arv, rr} = '0;
    {aw, ar, wd} = '0;
    md = 1'h1;
    ws = 4'hF;
    tick(3);
    resetn_in <= 1'h1;
    tick(2);
    chk("pg", pg, 1'h0);
    axi_rd(efuse_pkg::CTRL_OFFSET, d, r);
    chk("ctrl", d[0], efuse_pkg::CTRL_RESET);
    axi_wr(4'hC, 32'h1, r);
    chk("bresp", r, efuse_pkg::RESP_SLVERR);
    axi_rd(4'hC, d, r);
    chk("rresp", r, efuse_pkg::RESP_SLVERR);
    // Start-up, power-good, transient and persistent overcurrent
    {sd, lo} <= 2'h3;
    tick(8);
    chk("pg", pg, 1'h0);
    od <= 1'h1;
    tick(60);
    chk("pg", pg, 1'h0);
    tick(50);
    chk("pg", pg, 1'h1);
    oc <= 1'h1;
    tick(10);
    oc <= 1'h0;
    tick(5);
    chk("pg", pg, 1'h1);
    oc <= 1'h1;
    tick(45);
    chk("gate", gate, 1'h0);
    chk("line", line, 1'h0);
    chk("pg", pg, 1'h1);
    tick(110);
    chk("pg", pg, 1'h0);
    flt(7'h02);
    {lo, oc} <= 2'h0;
    tick(30);
    flt(7'h02);
    clr("breaker");
    // Discharge qualification and its stop conditions
    sd <= 1'h1;
    tick(15);
    chk("dis", dis, 1'h0);
    tick(15);
    chk("dis", dis, 1'h1);
    fb <= 1'h1;
    tick(5);
    chk("dis", dis, 1'h0);
    {sd, fb} <= 2'h0;
    tick(5);
    sd <= 1'h1;
    tick(30);
    ot <= 1'h1;
    tick(5);
    chk("dis", dis, 1'h0);
    clr("discharge");
    up();
    ot <= 1'h1;
    tick(5);
    {ot, cl} <= 2'h1;
    tick(150);
    chk("gate", gate, 1'h0);
    flt(7'h01);
    clr("latch-off");
    md <= 1'h0;
    up();
    ot <= 1'h1;
    tick(5);
    ot <= 1'h0;
    tick(100);
    chk("gate", gate, 1'h0);
    cl <= 1'h1;
    tick(30);
    chk("gate", gate, 1'h0);
    tick(40);
    chk("gate", gate, 1'h1);
    clr("retry");
    md <= 1'h1;
    up();
    pf <= 1'h1;
    tick(8);
    chk("gate", gate, 1'h0);
    flt(7'h40);
    clr("peer");
    up();
    ft <= 1'h1;
    tick(6);
    chk("gate", gate, 1'h0);
    flt(7'h04);
    clr("fast-trip");
    up();
    gs <= 1'h1;
    tick(efuse_pkg::GS_CYCLES - 20);
    chk("gate", gate, 1'h1);
    tick(40);
    chk("gate", gate, 1'h0);
    flt(7'h10);
    clr("gate-source");
    {sd, lo} <= 2'h3;
    tick(230);
    chk("gate", gate, 1'h0);
    chk("oe", oe, 1'h1);
    flt(7'h18);
    clr("timeout");
    {sd, gv} <= 2'h3;
    tick(6);
    flt(7'h20);
    clr("gate-drain");
    // Software inhibit holds the switch off; overvoltage opens it and drives the line
    axi_wr(efuse_pkg::CTRL_OFFSET, 32'h1, r);
    chk("bresp", r, efuse_pkg::RESP_OKAY);
    axi_rd(efuse_pkg::CTRL_OFFSET, d, r);
    chk("ctrl", d[0], 1'h1);
    {sd, lo, od} <= 3'h7;
    tick(8);
    chk("gate", gate, 1'h0);
    axi_wr(efuse_pkg::CTRL_OFFSET, 32'h0, r);
    tick(8);
    chk("gate", gate, 1'h1);
    axi_rd(efuse_pkg::STATE_OFFSET, d, r);
    chk("state", d[7:0], 8'h23);
    ov <= 1'h1;
    tick(6);
    chk("gate", gate, 1'h0);
    chk("oe", oe, 1'h1);
    ov <= 1'h0;
    clr("inhibit");
    close_out();
  end
endmodule : testbench
